// ---- design/interrupt_level_mask_pending.sv ----
// interrupt level mask register and timer pending flags
// assumes a byte-wide register port from the cpu core, synchronous to ref_clk_i
`timescale 1ns/10ps
`include "irq_mask_cfg.svh"

module interrupt_level_mask_pending #(
  parameter int SRC_PER_LEVEL = 4
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire irq_mask_pkg::reg_byte_t reg_addr_i,
  input wire irq_mask_pkg::reg_byte_t reg_wdata_i,
  output irq_mask_pkg::reg_byte_t reg_rdata_o,
  input wire logic [8*SRC_PER_LEVEL-1:0] level_src_i,
  input wire logic t1_ovf_i,
  input wire logic t1_match_i,
  input wire logic ta_ovf_i,
  output irq_mask_pkg::level_vec_t level_req_o,
  output irq_mask_pkg::pend_vec_t pend_o
);
  import irq_mask_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------
  // local sizes
  // ----------------------------------------
  localparam int NUM_LEVELS = 8;
  localparam int PEND_PAD = 8 - `PEND_USED_BITS;

  // ----------------------------------------
  // register select
  // ----------------------------------------
  logic mask_sel;
  logic pend_sel;

  // shared by every register select below
  function automatic logic addr_hit(input reg_byte_t addr, input reg_byte_t target);
    return addr == target;
  endfunction

  always_comb begin
    mask_sel = addr_hit(reg_addr_i, `LEVEL_MASK_ADDR);
    pend_sel = addr_hit(reg_addr_i, `TIMER_PEND_ADDR);
  end

  // ----------------------------------------
  // bus strobes
  // ----------------------------------------
  logic mask_wr;
  logic pend_wr;
  logic mask_rd;
  logic pend_rd;
  logic any_rd;

  // unmapped writes match no select and fall away here
  always_comb begin
    mask_wr = reg_wr_i && mask_sel;
    pend_wr = reg_wr_i && pend_sel;
    mask_rd = reg_rd_i && mask_sel;
    pend_rd = reg_rd_i && pend_sel;
    any_rd = reg_rd_i;
  end

  // ----------------------------------------
  // level mask register
  // ----------------------------------------
  reg_byte_t mask_r;
  reg_byte_t mask_nxt;

  always_comb begin
    mask_nxt = mask_r;
    if (mask_wr) begin
      mask_nxt = reg_wdata_i;
    end
  end

  // mask resets to zero: undefined in hardware, masked is the safe choice
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= `LEVEL_MASK_RESET;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // ----------------------------------------
  // timer pending flags
  // ----------------------------------------
  pend_vec_t pend_r;
  pend_vec_t pend_nxt;
  pend_vec_t set_vec;
  pend_vec_t keep_vec;

  // events gathered into their flag positions
  function automatic pend_vec_t pend_events(input logic t1_ovf, input logic t1_match, input logic ta_ovf);
    pend_vec_t v;
    v = '0;
    v[`PEND_T1_OVF_BIT] = t1_ovf;
    v[`PEND_T1_MATCH_BIT] = t1_match;
    v[`PEND_TA_OVF_BIT] = ta_ovf;
    return v;
  endfunction

  always_comb begin
    set_vec = pend_events(t1_ovf_i, t1_match_i, ta_ovf_i);
    keep_vec = '1;
    if (pend_wr) begin
      // writing one leaves a flag alone
      keep_vec = reg_wdata_i[`PEND_USED_BITS-1:0];
    end
    // a same-cycle event wins over the clear, so no request is lost
    pend_nxt = (pend_r & keep_vec) | set_vec;
  end

  // bits 7..3 have no storage at all
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= `PEND_RESET;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // ----------------------------------------
  // level requests toward the cpu
  // ----------------------------------------
  level_vec_t level_any;
  level_vec_t req_r;
  level_vec_t req_nxt;

  // any source of a level asserts it
  function automatic level_vec_t or_levels(input logic [8*SRC_PER_LEVEL-1:0] src);
    level_vec_t v;
    v = '0;
    for (int i = 0; i < NUM_LEVELS; i++) begin
      v[i] = |src[i*SRC_PER_LEVEL +: SRC_PER_LEVEL];
    end
    return v;
  endfunction

  always_comb begin
    level_any = or_levels(level_src_i);
    // masked levels withheld; bit 7 carries the port 0 upper pins
    req_nxt = level_any & mask_r;
  end

  // registered so the cpu never sees a decode glitch; costs one cycle
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      req_r <= 8'h00;
    end else begin
      req_r <= req_nxt;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  reg_byte_t rdata_r;
  reg_byte_t rdata_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    if (any_rd) begin
      // unmapped reads return zero rather than stale data
      rdata_nxt = 8'h00;
    end
    if (mask_rd) begin
      rdata_nxt = mask_r;
    end
    if (pend_rd) begin
      rdata_nxt = {{PEND_PAD{1'b0}}, pend_r};
    end
  end

  // holds until the next read so a slow cpu can fetch it late
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every output is a flip-flop, no logic after it
  assign reg_rdata_o = rdata_r;
  assign level_req_o = req_r;
  assign pend_o = pend_r;
endmodule

// ---- design/irq_mask_cfg.svh ----
// register offsets, field positions and reset values of the level mask block
// assumes inclusion by the package and the top module only
`ifndef IRQ_MASK_CFG_SVH
`define IRQ_MASK_CFG_SVH

`define LEVEL_MASK_ADDR 8'hDD
`define TIMER_PEND_ADDR 8'hD2
`define LEVEL_MASK_RESET 8'h00
`define PEND_RESET 3'h0
`define PEND_T1_OVF_BIT 2
`define PEND_T1_MATCH_BIT 1
`define PEND_TA_OVF_BIT 0
`define PEND_USED_BITS 3
`define LEVEL_SEVEN_BIT 7

`endif

// ---- design/irq_mask_pkg.sv ----
// types shared by the interrupt level mask block
// assumes irq_mask_cfg.svh is on the include path
package irq_mask_pkg;
  `include "irq_mask_cfg.svh"
  typedef logic [7:0] reg_byte_t;
  typedef logic [7:0] level_vec_t;
  typedef logic [`PEND_USED_BITS-1:0] pend_vec_t;
endpackage

// ---- sim/cpu_irq_model.sv ----
`timescale 1ns/10ps
// cpu side: counts level seven requests seen
module cpu_irq_model(input wire logic ref_clk_i, input wire logic [7:0] level_req_o, output logic [7:0] hits_o);
  initial hits_o = 8'h00;
  always @(posedge ref_clk_i) if (level_req_o[7]) hits_o <= hits_o + 8'h01;
endmodule

// ---- sim/ilmp_props.sv ----
// checker on the block ports, bound below
// assumes the top module port names of the block
`timescale 1ns/10ps
module ilmp_props (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic t1_ovf_i,
  input wire logic ta_ovf_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [31:0] level_src_i,
  input wire logic [7:0] level_req_o,
  input wire logic [2:0] pend_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence mask7_off_s;
    reg_wr_i && reg_addr_i == 8'hDD && !reg_wdata_i[7];
  endsequence
  sequence ta_clr_s;
    reg_wr_i && reg_addr_i == 8'hD2 && !reg_wdata_i[0] && !ta_ovf_i;
  endsequence
  sequence t1_keep_s;
    pend_o[2] && !(reg_wr_i && reg_addr_i == 8'hD2 && !reg_wdata_i[2]);
  endsequence
  sequence pend_rd_s;
    reg_rd_i && reg_addr_i == 8'hD2;
  endsequence
  AST_T1: assert property (t1_ovf_i |=> pend_o[2]) else $error("t1 flag not set");
  AST_TA: assert property (ta_ovf_i |=> pend_o[0]) else $error("ta flag not set");
  AST_REQ: assert property (level_req_o[7] |-> $past(|level_src_i[31:28])) else $error("req");
  AST_MASK: assert property (mask7_off_s |-> ##2 !level_req_o[7]) else $error("masked level seen");
  AST_CLR: assert property (ta_clr_s |=> !pend_o[0]) else $error("flag not cleared");
  AST_HOLD: assert property (t1_keep_s |=> pend_o[2]) else $error("flag lost");
  AST_RSV: assert property (pend_rd_s |=> reg_rdata_o[7:3] == 5'h00) else $error("unused bits set");
endmodule
bind interrupt_level_mask_pending ilmp_props i_p(.*);

// ---- sim/interrupt_level_mask_pending_tb.sv ----
`timescale 1ns/10ps
// bench; needs design, model, checker
module interrupt_level_mask_pending_tb;
  logic ref_clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0, ta_ovf_i = 0, t1_match_i = 0, t1_ovf_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, level_req_o, hits_o;
  logic [31:0] level_src_i = 0;
  logic [2:0] pend_o;
  wire c = ref_clk_i;
  logic [47:0] rows [3] = '{48'h80_10000000_80, 48'h00_10000000_00, 48'h7F_FFFFFFFF_7F};
  int num_errors = 0, samples_checked = 0, cyc = 0;
  interrupt_level_mask_pending i_interrupt_level_mask_pending(.*);
  cpu_irq_model i_cpu_irq_model(.*);
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge c) if (++cyc == 900) begin num_errors++; test_done; end
  task chk(logic [7:0] s, e, string n);
    samples_checked++;
    if (s !== e) begin num_errors++; $display("Error %s exp %h got %h", n, e, s); end
  endtask
  task acc(logic w, logic [7:0] x, y);
    @(negedge c) {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {w, !w, x, y};
    @(negedge c) {reg_wr_i, reg_rd_i} = 0;
  endtask
  task test_done;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge c);
    nrst_i = 1;
    repeat (2) @(negedge c);
    acc(0, 8'hD2, 0);
    chk(reg_rdata_o, 0, "pend");
    foreach (rows[i]) begin
      acc(1, 8'hDD, rows[i][47:40]);
      level_src_i = rows[i][39:8];
      repeat (3) @(negedge c);
      chk(level_req_o, rows[i][7:0], "req");
    end
    chk(hits_o != 0, 1, "cpu");
    @(negedge c) {t1_ovf_i, ta_ovf_i} = 2'b11;
    @(negedge c) {t1_ovf_i, ta_ovf_i} = 2'b00;
    acc(0, 8'hD2, 0);
    chk(reg_rdata_o, 8'h05, "pend");
    acc(1, 8'hD2, 8'hFE);
    acc(0, 8'hD2, 0);
    chk(reg_rdata_o, 8'h04, "pend");
    acc(0, 8'hDD, 0);
    chk(reg_rdata_o, 8'h7F, "mask");
    @(negedge c) t1_match_i = 1;
    @(negedge c) t1_match_i = 0;
    chk({5'h00, pend_o}, 8'h06, "pend_o");
    @(negedge c) {reg_wr_i, reg_addr_i, reg_wdata_i, ta_ovf_i} = {1'b1, 8'hD2, 8'h00, 1'b1};
    @(negedge c) {reg_wr_i, ta_ovf_i} = 2'b00;
    chk({5'h00, pend_o}, 8'h01, "race");
    acc(0, 8'h10, 0);
    chk(reg_rdata_o, 0, "void");
    @(negedge c) nrst_i = 0;
    @(negedge c) chk({5'h00, pend_o}, 0, "rst_pend");
    chk(level_req_o, 0, "rst_req");
    nrst_i = 1;
    repeat (4) @(negedge c);
    chk(level_req_o, 0, "rst_mask");
    test_done;
  end
endmodule
